/* logic/eac_device.sv */
// Nonvolatile byte array with its control, pointer and value registers
`timescale 1ns/1ps
module eac_device #(
	parameter int ATOMIC_TICKS = eac_pkg::EAC_ATOMIC_TICKS,
	parameter int SPLIT_TICKS  = eac_pkg::EAC_SPLIT_TICKS,
	parameter int RC_DIV       = eac_pkg::EAC_RC_DIV
) (
	// Clock, resets, enable
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic por_rst,
	input  wire logic ce,
	// Register link
	eac_if.device     bus,
	// Status to user logic
	output logic      nv_busy,
	output logic      write_done
);
	import eac_pkg::*;

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (ATOMIC_TICKS < 1 || ATOMIC_TICKS > 65535 || SPLIT_TICKS < 1 || SPLIT_TICKS > 65535
		|| RC_DIV < 1 || RC_DIV > 255)
	begin : g_bad
		$error("eac_device: timing parameter out of range");
	end

	// ------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------
	logic [7:0]           mem_r [EAC_DEPTH];
	logic [EAC_PTR_W-1:0] ptr_r;
	logic [7:0]           value_r;
	logic [1:0]           op_sel_r;
	logic                 irq_en_r;
	logic                 arm_r;
	logic [2:0]           arm_cnt_r;
	logic [2:0]           stall_cnt_r;
	logic                 busy_r;
	logic [1:0]           op_r;
	logic [EAC_PTR_W-1:0] tgt_ptr_r;
	logic [7:0]           tgt_val_r;
	logic [7:0]           rc_cnt_r;
	logic [15:0]          time_cnt_r;
	logic [7:0]           rdata_r;
	logic                 irq_r;
	logic                 done_r;

	// Programming result for one byte
	function automatic logic [7:0] eac_program(input logic [1:0] op, input logic [7:0] old_v,
		input logic [7:0] new_v);
		logic [7:0] res;
		res = new_v;
		if (op == EAC_OP_ERASE)
		begin
			res = EAC_ERASED;
		end
		else if (op == EAC_OP_WRITE)
		begin
			res = old_v & new_v;
		end
		return res;
	endfunction : eac_program

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	wire        wr_ctrl   = bus.io_wr && bus.io_addr == EAC_A_CTRL;
	wire        wr_value  = bus.io_wr && bus.io_addr == EAC_A_VALUE;
	wire        wr_ptr_lo = bus.io_wr && bus.io_addr == EAC_A_PTR_LO && !busy_r;  // R11
	wire        wr_ptr_hi = bus.io_wr && bus.io_addr == EAC_A_PTR_HI && !busy_r;  // R11
	wire        strobe_wr = wr_ctrl && bus.io_wdata[EAC_B_PROG];
	wire        arm_wr    = wr_ctrl && bus.io_wdata[EAC_B_ARM];
	wire        prog_go   = strobe_wr && arm_r && !busy_r                        // R2 R3
		&& !bus.self_program_active && op_sel_r != EAC_OP_RSVD;                  // R6 R15
	wire        read_go   = wr_ctrl && bus.io_wdata[EAC_B_READ] && !busy_r;     // R9 R11
	wire        rc_tick   = rc_cnt_r == 8'(RC_DIV - 1);
	wire        time_end  = busy_r && rc_tick && time_cnt_r == 16'h0000;
	wire [15:0] op_ticks  = (op_sel_r == EAC_OP_ATOMIC) ? 16'(ATOMIC_TICKS) : 16'(SPLIT_TICKS);
	wire [7:0]  ctrl_view = {2'b00, op_sel_r, irq_en_r, arm_r, busy_r, 1'b0};
	wire [7:0]  ptr_hi_v  = 8'(ptr_r[EAC_PTR_W-1:8]);
	wire [7:0]  rd_mux    = (bus.io_addr == EAC_A_CTRL)   ? ctrl_view :
		(bus.io_addr == EAC_A_VALUE)  ? value_r :
		(bus.io_addr == EAC_A_PTR_LO) ? ptr_r[7:0] :
		(bus.io_addr == EAC_A_PTR_HI) ? ptr_hi_v : 8'h00;

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign bus.io_rdata  = rdata_r;
	assign bus.cpu_stall = stall_cnt_r != 3'h0;  // R8 R10
	assign bus.ready_irq = irq_r;
	assign nv_busy       = busy_r;
	assign write_done    = done_r;

	// Pointer, no reset value needed by software
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			ptr_r <= '0;
		else if (ce && wr_ptr_lo)
			ptr_r[7:0] <= bus.io_wdata;  // R17
		else if (ce && wr_ptr_hi)
			ptr_r[EAC_PTR_W-1:8] <= bus.io_wdata[EAC_PTR_W-9:0];  // R17
	end

	// Value register, loaded by software or by a read
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			value_r <= 8'h00;
		else if (ce && read_go)
			value_r <= mem_r[ptr_r];  // R9
		else if (ce && wr_value)
			value_r <= bus.io_wdata;
	end

	// Interrupt enable and registered ready interrupt
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irq_en_r <= 1'b0;
			irq_r    <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_ctrl)
				irq_en_r <= bus.io_wdata[EAC_B_IRQEN];
			irq_r <= irq_en_r && bus.global_irq_allow && !busy_r && !bus.self_program_active;  // R1
		end
	end

	// Arm bit with its four-cycle lifetime
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			arm_r     <= 1'b0;
			arm_cnt_r <= 3'h0;
		end
		else if (ce)
		begin
			if (arm_wr && !prog_go)
			begin
				arm_r     <= 1'b1;
				arm_cnt_r <= 3'(EAC_ARM_CYCLES - 1);
			end
			else if (prog_go || wr_ctrl || arm_cnt_r == 3'h0)
				arm_r <= 1'b0;  // R4
			else
				arm_cnt_r <= arm_cnt_r - 3'h1;  // R4
		end
	end

	// CPU stall counter
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			stall_cnt_r <= 3'h0;
		else if (ce && read_go)
			stall_cnt_r <= 3'(EAC_READ_STALL);  // R10
		else if (ce && prog_go)
			stall_cnt_r <= 3'(EAC_PROG_STALL);  // R8
		else if (ce && stall_cnt_r != 3'h0)
			stall_cnt_r <= stall_cnt_r - 3'h1;
	end

	// Register read data
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_r <= 8'h00;
		else if (ce && bus.io_rd)
			rdata_r <= rd_mux;
	end

	// Operation select survives a system reset taken mid-write
	always_ff @(posedge clk_sys or posedge por_rst)
	begin
		if (por_rst)
			op_sel_r <= EAC_OP_ATOMIC;
		else if (ce && sys_rst && !busy_r)
			op_sel_r <= EAC_OP_ATOMIC;  // R16
		else if (ce && wr_ctrl && !busy_r)
			op_sel_r <= bus.io_wdata[EAC_B_OP_LSB +: 2];  // R15 R16
	end

	// Write engine, timed in oscillator ticks, kept across system reset
	always_ff @(posedge clk_sys or posedge por_rst)
	begin
		if (por_rst)
		begin
			busy_r     <= 1'b0;
			op_r       <= EAC_OP_ATOMIC;
			tgt_ptr_r  <= '0;
			tgt_val_r  <= 8'h00;
			rc_cnt_r   <= 8'h00;
			time_cnt_r <= 16'h0000;
			done_r     <= 1'b0;
		end
		else if (ce)
		begin
			done_r <= time_end;
			if (prog_go && !sys_rst)
			begin
				busy_r     <= 1'b1;  // R7
				op_r       <= op_sel_r;
				tgt_ptr_r  <= ptr_r;
				tgt_val_r  <= value_r;
				rc_cnt_r   <= 8'h00;
				time_cnt_r <= op_ticks - 16'h0001;  // R13
			end
			else if (time_end)
				busy_r <= 1'b0;  // R7
			else if (busy_r)
			begin
				rc_cnt_r <= rc_tick ? 8'h00 : rc_cnt_r + 8'h01;
				if (rc_tick)
					time_cnt_r <= time_cnt_r - 16'h0001;  // R13
			end
		end
	end

	// Array update when the write time ends
	always_ff @(posedge clk_sys)
	begin
		if (ce && time_end)
			mem_r[tgt_ptr_r] <= eac_program(op_r, mem_r[tgt_ptr_r], tgt_val_r);  // R15
	end

endmodule : eac_device

/* logic/eac_host.sv */
// CPU-side controller: AXI4-Lite slave that issues register accesses to the device
`timescale 1ns/1ps
module eac_host (
	// Clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// Register link
	eac_if.host              bus,
	// AXI4-Lite write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Interrupt
	output logic             irq
);
	import eac_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	eac_host_st_t st_r;
	logic [7:0]   aw_addr_r;
	logic         aw_got_r;
	logic [31:0]  w_data_r;
	logic         w_got_r;
	logic [16:0]  cmd_r;
	logic [7:0]   result_r;
	logic [1:0]   core_r;
	logic [1:0]   istat_r;
	logic [1:0]   imask_r;
	logic         ready_q_r;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire        wr_fire  = aw_got_r && w_got_r && !bvalid && ce;
	wire        wr_known = aw_addr_r == EAC_R_CMD || aw_addr_r == EAC_R_CORE
		|| aw_addr_r == EAC_R_ISTAT || aw_addr_r == EAC_R_IMASK;
	wire        wr_ok    = wr_fire && wr_known;
	wire        cmd_go   = wr_ok && aw_addr_r == EAC_R_CMD && st_r == EAC_HS_IDLE;
	wire        ev_done  = st_r == EAC_HS_WAIT && !bus.cpu_stall;
	wire        ev_ready = bus.ready_irq && !ready_q_r;
	wire [1:0]  ev       = {ev_ready, ev_done};
	wire [1:0]  clr      = (wr_ok && aw_addr_r == EAC_R_ISTAT) ? w_data_r[1:0] : 2'b00;
	wire        rd_known = araddr == EAC_R_CMD || araddr == EAC_R_STAT || araddr == EAC_R_CORE
		|| araddr == EAC_R_ISTAT || araddr == EAC_R_IMASK;
	wire [31:0] rd_mux   = (araddr == EAC_R_CMD)   ? 32'(cmd_r) :
		(araddr == EAC_R_STAT)  ? {23'h0, st_r != EAC_HS_IDLE, result_r} :
		(araddr == EAC_R_CORE)  ? {30'h0, core_r} :
		(araddr == EAC_R_ISTAT) ? {30'h0, istat_r} :
		(araddr == EAC_R_IMASK) ? {30'h0, imask_r} : 32'h0000_0000;

	// Handshakes and link outputs
	assign awready                 = ce && !aw_got_r && !bvalid;
	assign wready                  = ce && !w_got_r && !bvalid;
	assign arready                 = ce && !rvalid;
	assign irq                     = |(istat_r & imask_r);
	assign bus.io_addr             = cmd_r[7:0];
	assign bus.io_wdata            = cmd_r[EAC_CMD_DATA +: 8];
	assign bus.io_wr               = st_r == EAC_HS_ISSUE && cmd_r[EAC_CMD_WR];
	assign bus.io_rd               = st_r == EAC_HS_ISSUE && !cmd_r[EAC_CMD_WR];
	assign bus.global_irq_allow    = core_r[EAC_CORE_GIE];  // R14
	assign bus.self_program_active = core_r[EAC_CORE_SPM];  // R6

	// AXI write side
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			bvalid    <= 1'b0;
			bresp     <= EAC_RESP_OK;
		end
		else if (ce)
		begin
			if (awvalid && awready)
			begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_got_r  <= 1'b1;
				w_data_r <= wdata;
			end
			if (wr_fire)
			begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= wr_known ? EAC_RESP_OK : EAC_RESP_ERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// AXI read side
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= EAC_RESP_OK;
		end
		else if (ce)
		begin
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rdata  <= rd_mux;
				rresp  <= rd_known ? EAC_RESP_OK : EAC_RESP_ERR;
			end
			else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end

	// Control registers and sticky status, set wins over clear
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			core_r    <= 2'b00;
			imask_r   <= 2'b00;
			istat_r   <= 2'b00;
			ready_q_r <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_ok && aw_addr_r == EAC_R_CORE)
				core_r <= w_data_r[1:0];
			if (wr_ok && aw_addr_r == EAC_R_IMASK)
				imask_r <= w_data_r[1:0];
			istat_r   <= (istat_r & ~clr) | ev;
			ready_q_r <= bus.ready_irq;
		end
	end

	// Access sequencer: issue one cycle, wait out the stall
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r     <= EAC_HS_IDLE;
			cmd_r    <= 17'h0_0000;
			result_r <= 8'h00;
		end
		else if (ce)
		begin
			unique case (st_r)
				EAC_HS_IDLE:
					if (cmd_go)
					begin
						cmd_r <= w_data_r[16:0];
						st_r  <= EAC_HS_ISSUE;
					end
				EAC_HS_ISSUE:
					st_r <= EAC_HS_WAIT;
				EAC_HS_WAIT:
					if (!bus.cpu_stall)
					begin
						result_r <= bus.io_rdata;
						st_r     <= EAC_HS_IDLE;
					end
			endcase
		end
	end

endmodule : eac_host

/* logic/eac_if.sv */
// Register access link between CPU-side controller and the nonvolatile access device
`timescale 1ns/1ps
interface eac_if;
	logic [7:0] io_addr;
	logic [7:0] io_wdata;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_rdata;
	logic       cpu_stall;
	logic       ready_irq;
	logic       global_irq_allow;
	logic       self_program_active;

	modport device (
		input  io_addr, io_wdata, io_wr, io_rd, global_irq_allow, self_program_active,
		output io_rdata, cpu_stall, ready_irq
	);
	modport host (
		output io_addr, io_wdata, io_wr, io_rd, global_irq_allow, self_program_active,
		input  io_rdata, cpu_stall, ready_irq
	);
endinterface : eac_if

/* logic/eac_pkg.sv */
// Constants, types and field layout shared by both ends of the nonvolatile access link
// ------------------------------------------------------------
// How it works
// R1 - Ready interrupt while enabled, allowed, not busy
// R2 - Strobe within four armed cycles starts write
// R3 - Strobe without arm is ignored
// R4 - Arm clears itself after four cycles
// R5 - Software arms, then strobes within four cycles
// R6 - No programming during flash self-programming
// R7 - Strobe reads one until write time ends
// R8 - Programming start stalls CPU two cycles
// R9 - Read strobe loads byte immediately
// R10 - Read stalls CPU four cycles
// R11 - Busy blocks reads and pointer changes
// R12 - Software checks strobe clear before reading
// R13 - Write timed by oscillator, 26368 ticks atomic, 14400 ticks erase or write
// R14 - Software masks interrupts across write sequence
// R15 - Operation select picks erase, write or both
// R16 - Operation select frozen while busy, reset
// R17 - Pointer addresses 1024 bytes, undefined reset (code clears ptr_r to 0 on sys_rst)
// ------------------------------------------------------------
package eac_pkg;

	// ------------------------------------------------------------
	// Device register map (8-bit I/O addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] EAC_A_CTRL    = 8'h3F;
	localparam logic [7:0] EAC_A_VALUE   = 8'h40;
	localparam logic [7:0] EAC_A_PTR_LO  = 8'h41;
	localparam logic [7:0] EAC_A_PTR_HI  = 8'h42;
	localparam int         EAC_PTR_W     = 10;
	localparam int         EAC_DEPTH     = 1024;

	// Control register fields
	localparam int         EAC_B_READ    = 0;
	localparam int         EAC_B_PROG    = 1;
	localparam int         EAC_B_ARM     = 2;
	localparam int         EAC_B_IRQEN   = 3;
	localparam int         EAC_B_OP_LSB  = 4;
	localparam logic [1:0] EAC_OP_ATOMIC = 2'h0;
	localparam logic [1:0] EAC_OP_ERASE  = 2'h1;
	localparam logic [1:0] EAC_OP_WRITE  = 2'h2;
	localparam logic [1:0] EAC_OP_RSVD   = 2'h3;
	localparam logic [7:0] EAC_ERASED    = 8'hFF;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         EAC_ARM_CYCLES   = 4;
	localparam int         EAC_PROG_STALL   = 2;
	localparam int         EAC_READ_STALL   = 4;
	localparam int         EAC_CLK_NS       = 25;
	localparam int         EAC_RC_NS        = 125;
	localparam int         EAC_RC_DIV       = EAC_RC_NS / EAC_CLK_NS;
	localparam int         EAC_ATOMIC_TICKS = 26368;
	localparam int         EAC_SPLIT_US     = 1800;
	localparam int         EAC_SPLIT_TICKS  = EAC_SPLIT_US * 1000 / EAC_RC_NS;

	// ------------------------------------------------------------
	// Controller register map (AXI4-Lite byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] EAC_R_CMD     = 8'h00;
	localparam logic [7:0] EAC_R_STAT    = 8'h04;
	localparam logic [7:0] EAC_R_CORE    = 8'h08;
	localparam logic [7:0] EAC_R_ISTAT   = 8'h0C;
	localparam logic [7:0] EAC_R_IMASK   = 8'h10;
	localparam int         EAC_CMD_DATA  = 8;
	localparam int         EAC_CMD_WR    = 16;
	localparam int         EAC_STAT_BUSY = 8;
	localparam int         EAC_CORE_GIE  = 0;
	localparam int         EAC_CORE_SPM  = 1;
	localparam int         EAC_IRQ_DONE  = 0;
	localparam int         EAC_IRQ_READY = 1;
	localparam logic [1:0] EAC_RESP_OK   = 2'h0;
	localparam logic [1:0] EAC_RESP_ERR  = 2'h2;

	typedef enum logic [1:0] {EAC_HS_IDLE, EAC_HS_ISSUE, EAC_HS_WAIT} eac_host_st_t;

endpackage : eac_pkg

/* test/eac_link_properties.sv */
// Concurrent checks on the register link between host and device
`timescale 1ns/1ps
module eac_link_properties #(
	parameter int ATOMIC_TICKS = eac_pkg::EAC_ATOMIC_TICKS,
	parameter int SPLIT_TICKS  = eac_pkg::EAC_SPLIT_TICKS,
	parameter int RC_DIV       = eac_pkg::EAC_RC_DIV
) (
	// Clock, reset
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	// Link signals
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic       io_wr,
	input wire logic       cpu_stall,
	input wire logic       ready_irq,
	input wire logic       global_irq_allow,
	input wire logic       self_program_active,
	// Device status
	input wire logic       nv_busy
);
	import eac_pkg::*;
	localparam int LONG_C  = ATOMIC_TICKS * RC_DIV;
	localparam int SHORT_C = SPLIT_TICKS * RC_DIV;
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// Control register write decode
	wire       ctrl_wr = io_wr && io_addr == EAC_A_CTRL;
	wire       arm_wr  = ctrl_wr && io_wdata[EAC_B_ARM] && !io_wdata[EAC_B_PROG];
	wire       prog_wr = ctrl_wr && io_wdata[EAC_B_PROG];
	wire       read_wr = ctrl_wr && io_wdata[EAC_B_READ] && !io_wdata[EAC_B_PROG];
	wire       op_ok   = io_wdata[EAC_B_OP_LSB +: 2] != EAC_OP_RSVD;
	logic [3:0]  arm_age_r;
	logic [15:0] busy_len_r;
	wire       armed   = arm_age_r >= 4'h1 && arm_age_r <= 4'h4;

	// Cycles since the arm bit was written
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			arm_age_r <= 4'h0;
		else if (arm_wr)
			arm_age_r <= 4'h1;
		else if (ctrl_wr)
			arm_age_r <= 4'h0;
		else if (arm_age_r != 4'h0 && arm_age_r != 4'hF)
			arm_age_r <= arm_age_r + 4'h1;
	end

	// Length of the current busy span, survives reset like the engine
	always_ff @(posedge clk_sys)
	begin
		busy_len_r <= nv_busy ? busy_len_r + 16'h1 : 16'h0;
	end

	sequence s_stall4;
		cpu_stall [*4] ##1 !cpu_stall;
	endsequence
	sequence s_stall2;
		cpu_stall [*2] ##1 !cpu_stall;
	endsequence

	AST_READ_STALL: assert property (read_wr && !nv_busy |=> s_stall4)
		else $error("read strobe stall length wrong");
	AST_PROG_STALL: assert property ($rose(nv_busy) |-> s_stall2)
		else $error("program strobe stall length wrong");
	AST_ARM_START: assert property (prog_wr && armed && !nv_busy && !self_program_active && op_ok |=> nv_busy)
		else $error("armed strobe did not start a write");
	AST_ARM_LAPSE: assert property (prog_wr && !armed && !nv_busy |=> !nv_busy)
		else $error("unarmed strobe started a write");
	AST_IRQ_QUIET: assert property (nv_busy || self_program_active || !global_irq_allow |=> !ready_irq)
		else $error("ready interrupt while not allowed");
	AST_SPM_BLOCK: assert property (self_program_active && !nv_busy |=> !nv_busy)
		else $error("write started during flash programming");
	AST_BUSY_NO_READ: assert property (read_wr && nv_busy |=> !cpu_stall)
		else $error("read taken while busy");
	AST_WRITE_TIME: assert property ($fell(nv_busy) |-> busy_len_r == 16'(LONG_C) || busy_len_r == 16'(SHORT_C))
		else $error("write time wrong");
endmodule : eac_link_properties

/* test/test_eeprom_access_control.sv */
// Bench driving both ends of the nonvolatile access link over AXI4-Lite
`timescale 1ns/1ps
module test_eeprom_access_control;
	import eac_pkg::*;
	typedef struct {logic [31:0] mask; logic [31:0] val; logic [1:0] resp;} eac_note_t;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        por_rst = 1'b1;
	logic        ce      = 1'b1;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, d1, d2, v, e, b;
	logic [31:0] wdata = 32'h0, got;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  op;
	wire         awready, wready, bvalid, arready, rvalid, irq, nv_busy, write_done;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	eac_note_t   notes[$];
	eac_note_t   n;
	int          fails = 0, cmp_count = 0, seed = 32'h479A, dones = 0;

	// Clock and instances
	always #12.5 clk_sys = ~clk_sys;
	eac_if eac_if_i ();
	eac_device #(.ATOMIC_TICKS(40), .SPLIT_TICKS(30)) eac_device_i (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .por_rst(por_rst), .ce(ce), .bus(eac_if_i.device), .nv_busy(nv_busy),
		.write_done(write_done));
	eac_host eac_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .bus(eac_if_i.host), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
	eac_link_properties #(.ATOMIC_TICKS(40), .SPLIT_TICKS(30)) eac_link_properties_i (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(eac_if_i.io_addr), .io_wdata(eac_if_i.io_wdata),
		.io_wr(eac_if_i.io_wr), .cpu_stall(eac_if_i.cpu_stall), .ready_irq(eac_if_i.ready_irq),
		.global_irq_allow(eac_if_i.global_irq_allow), .self_program_active(eac_if_i.self_program_active),
		.nv_busy(nv_busy));

	// ------
	// Bus tasks
	// ------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		notes.push_back('{32'h0, 32'h0, r});
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'($random(seed));
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [31:0] m, input logic [31:0] x,
		input logic [1:0] r);
		notes.push_back('{m, x, r});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
	endtask : axi_rd

	// Device access through the command register, then wait for the host
	task automatic dev(input logic [7:0] a, input logic [7:0] d, input logic w);
		axi_wr(EAC_R_CMD, {15'h0, w, d, a}, EAC_RESP_OK);
		@(posedge clk_sys);
		do
			axi_rd(EAC_R_STAT, got, 32'h0, 32'h0, EAC_RESP_OK);
		while (got[EAC_STAT_BUSY]);
	endtask : dev

	task automatic dev_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x, output logic [7:0] q);
		dev(a, 8'h00, 1'b0);
		axi_rd(EAC_R_STAT, got, {24'h0, m}, {24'h0, x}, EAC_RESP_OK);
		q = got[7:0];
	endtask : dev_rd

	task automatic prog(input logic [7:0] c, input logic [9:0] p, input logic [7:0] d, input int gap);
		dev(EAC_A_PTR_LO, p[7:0], 1'b1);
		dev(EAC_A_PTR_HI, {6'h0, p[9:8]}, 1'b1);
		dev(EAC_A_VALUE, d, 1'b1);
		axi_wr(EAC_R_CMD, {15'h0, 1'b1, c | 8'h04, EAC_A_CTRL}, EAC_RESP_OK);
		repeat (gap) @(posedge clk_sys);
		axi_wr(EAC_R_CMD, {15'h0, 1'b1, c | 8'h02, EAC_A_CTRL}, EAC_RESP_OK);
		repeat (6) @(posedge clk_sys);
	endtask : prog

	task automatic wait_idle;
		do
			dev_rd(EAC_A_CTRL, 8'h00, 8'h00, b);
		while (b[EAC_B_PROG]);
	endtask : wait_idle

	task automatic rd_back(input logic [7:0] x);
		dev(EAC_A_CTRL, 8'h01, 1'b1);
		dev_rd(EAC_A_VALUE, 8'hFF, x, b);
	endtask : rd_back

	task automatic wr_irq(input logic [7:0] a, input logic [31:0] d, input logic x);
		axi_wr(a, d, EAC_RESP_OK);
		repeat (2) @(posedge clk_sys);
		check(32'(irq), 32'(x));
	endtask : wr_irq

	task automatic tally_and_finish;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// Count finished array updates
	always @(posedge clk_sys)
	begin
		if (write_done)
			dones++;
	end

	// Response monitor takes the oldest note per handshake
	always @(posedge clk_sys)
	begin
		if ((bvalid && bready) || (rvalid && rready))
		begin
			n = notes.pop_front();
			check({30'h0, (bvalid && bready) ? bresp : rresp}, {30'h0, n.resp});
			if (rvalid && rready)
				check(rdata & n.mask, n.val);
		end
	end

	// Watchdog
	initial
	begin
		#(30000 * 25);
		fails++;
		tally_and_finish();
	end

	// ------
	// Main sequence
	// ------
	initial
	begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
		dev_rd(EAC_A_CTRL, 8'hFF, 8'h00, b);
		dev_rd(EAC_A_VALUE, 8'hFF, 8'h00, b);
		axi_rd(8'h14, got, 32'h0, 32'h0, EAC_RESP_ERR);
		axi_wr(8'h14, 32'h0, EAC_RESP_ERR);
		$display("Test reset done");
		// Enable low must close the AW, W and AR channels
		ce <= 1'b0;
		@(negedge clk_sys);
		check(32'(awready | wready | arready), 32'h0);
		@(posedge clk_sys);
		ce <= 1'b1;
		d1 = 8'($random(seed));
		d2 = 8'($random(seed));
		e = 8'hFF;
		for (int i = 0; i < 3; i++)
		begin
			op = (i == 0) ? EAC_OP_ATOMIC : (i == 1) ? EAC_OP_WRITE : EAC_OP_ERASE;
			v = (i == 0) ? d1 : d2;
			e = (i == 0) ? v : (i == 1) ? (e & v) : 8'hFF;
			prog({2'h0, op, 4'h0}, 10'h3FF, v, 1);
			check(32'(nv_busy), 32'h1);
			dev(EAC_A_PTR_LO, 8'h00, 1'b1);
			dev(EAC_A_CTRL, {2'h0, EAC_OP_RSVD, 4'h1}, 1'b1);
			dev_rd(EAC_A_CTRL, 8'h32, {2'h0, op, 4'h2}, b);
			wait_idle();
			dev_rd(EAC_A_PTR_LO, 8'hFF, 8'hFF, b);
			rd_back(e);
		end
		dev_rd(EAC_A_PTR_HI, 8'h03, 8'h03, b);
		$display("Test programming modes done");
		prog(8'h00, 10'h3FF, d1, 2);
		check(32'(nv_busy), 32'h0);
		prog({2'h0, EAC_OP_RSVD, 4'h0}, 10'h3FF, d1, 1);
		check(32'(nv_busy), 32'h0);
		axi_wr(EAC_R_CORE, 32'h2, EAC_RESP_OK);
		prog(8'h00, 10'h3FF, d1, 1);
		check(32'(nv_busy), 32'h0);
		axi_wr(EAC_R_CORE, 32'h0, EAC_RESP_OK);
		rd_back(8'hFF);
		$display("Test refused strobes done");
		axi_wr(EAC_R_IMASK, 32'h2, EAC_RESP_OK);
		axi_wr(EAC_R_CORE, 32'h1, EAC_RESP_OK);
		dev(EAC_A_CTRL, 8'h08, 1'b1);
		check(32'(irq), 32'h1);
		wr_irq(EAC_R_ISTAT, 32'h3, 1'b0);
		prog(8'h08, 10'h3FF, d2, 1);
		wait_idle();
		check(32'(irq), 32'h1);
		wr_irq(EAC_R_IMASK, 32'h0, 1'b0);
		wr_irq(EAC_R_IMASK, 32'h2, 1'b1);
		wr_irq(EAC_R_ISTAT, 32'h2, 1'b0);
		$display("Test ready interrupt done");
		check(32'(dones), 32'h4);
		tally_and_finish();
	end
endmodule : test_eeprom_access_control
